// ### rtl/psp_payload_builder.v
// pixel shader thread payload builder, normal dispatch
// Functional notes
// - registers numbered from zero; omitted phases compact later registers downward
// - no gaps inside the payload; gaps only before constant and setup data
// - dword seven: snapshot flag bit 31, primitive thread count low 24 bits
// - dword six low 24 bits: thread counter incremented per dispatched thread
// - dword five bits 31:10: 1 KB aligned scratch pointer offset
// - dword five: color code bits 9:8, thread tag bits 7:0
// - dword four bits 31:5: binding table pointer, bits 4:0 reserved
// - dword three bits 31:5: sampler state table pointer
// - dword three bits 3:0: per-thread scratch size code 0 to 11
// - dword two delivered as all zeros
// - dword one bits 31:6: 64-byte aligned block_a pointer
// - dword zero bits 30:27: viewport index
// - dword zero bits 26:16: render target array index
// - dword zero bit 15: facing, 0 front, 1 back
// - dword zero bit 13 source depth to target, bit 12 coverage mask
// - dword zero bit 6: starting sample pair index, bits 8:7 reserved
// - dword zero bits 4:0: topology type passed unchanged
// - register one dword seven: lit mask high half, identical copy low half
// - dispatch mask enables whole subspan when any pixel lit
// - register one dwords five..two: subspan 3..0 upper-left Y high, X low
// - register two only for 32-pixel dispatch, subspans 7..4
// - barycentric phases only when enabled; slot 8..15 regs omitted in 8-pixel
`timescale 1ns/1ps
`include "psp_map.vh"
module psp_payload_builder
(
	clk_sys,
	reset_n,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	disp_valid,
	disp_ready,
	disp_simd,
	disp_snapshot,
	disp_prim_tid,
	disp_scratch_ptr,
	disp_color_code,
	disp_thread_tag,
	disp_bind_ptr,
	disp_sampler_ptr,
	disp_scratch_size,
	disp_cc_ptr,
	disp_viewport,
	disp_rt_index,
	disp_back_facing,
	disp_sspi,
	disp_topology,
	disp_lit_mask,
	disp_coords,
	bary_mode,
	bary_group,
	bary_coef,
	bary_data,
	exec_mask,
	pay_valid,
	pay_ready,
	pay_index,
	pay_data,
	pay_end,
	pay_count
);
	parameter TID_W = 24;

	input  wire                   clk_sys;
	input  wire                   reset_n;
	input  wire [`PSP_ADDR_W-1:0] reg_addr;
	input  wire [31:0]            reg_wdata;
	input  wire                   reg_wr;
	input  wire                   reg_rd;
	output reg  [31:0]            reg_rdata;
	input  wire                   disp_valid;
	output wire                   disp_ready;
	input  wire [1:0]             disp_simd;
	input  wire                   disp_snapshot;
	input  wire [23:0]            disp_prim_tid;
	input  wire [21:0]            disp_scratch_ptr;
	input  wire [1:0]             disp_color_code;
	input  wire [7:0]             disp_thread_tag;
	input  wire [26:0]            disp_bind_ptr;
	input  wire [26:0]            disp_sampler_ptr;
	input  wire [3:0]             disp_scratch_size;
	input  wire [25:0]            disp_cc_ptr;
	input  wire [3:0]             disp_viewport;
	input  wire [10:0]            disp_rt_index;
	input  wire                   disp_back_facing;
	input  wire                   disp_sspi;
	input  wire [4:0]             disp_topology;
	input  wire [31:0]            disp_lit_mask;
	input  wire [255:0]           disp_coords;
	output wire [2:0]             bary_mode;
	output wire                   bary_group;
	output wire                   bary_coef;
	input  wire [255:0]           bary_data;
	output reg  [31:0]            exec_mask;
	output reg                    pay_valid;
	input  wire                   pay_ready;
	output reg  [5:0]             pay_index;
	output reg  [255:0]           pay_data;
	output reg                    pay_end;
	output reg  [5:0]             pay_count;

	localparam ST_IDLE = 1'b0;
	localparam ST_SEND = 1'b1;

	// ****************************************************************
	// register port
	// ****************************************************************
	reg  [31:0]      cfg_q;
	reg  [TID_W-1:0] tid_q;
	reg              state_q;
	reg  [5:0]       last_len_q;

	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			cfg_q <= `PSP_CFG_RESET;
		else if (reg_wr && reg_addr == `PSP_OFF_CFG)
			cfg_q <= reg_wdata;
	end

	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			reg_rdata <= 32'h0000_0000;
		else if (reg_rd)
		begin
			case (reg_addr)
				`PSP_OFF_CFG:    reg_rdata <= cfg_q;
				`PSP_OFF_STATUS: reg_rdata <= {state_q, {(31-TID_W){1'b0}}, tid_q};
				`PSP_OFF_LAST:   reg_rdata <= {26'h000_0000, last_len_q};
				default:         reg_rdata <= 32'h0000_0000;
			endcase
		end
		else
			reg_rdata <= 32'h0000_0000;
	end

	// ****************************************************************
	// dispatch capture
	// ****************************************************************
	wire         take;
	wire [31:0]  exec_d;
	reg  [1:0]   simd_q;
	reg  [5:0]   bary_en_q;
	reg  [255:0] hdr_q;
	reg  [255:0] r1_q;
	reg  [255:0] r2_q;
	reg  [31:0]  dw0_d;
	reg  [255:0] hdr_d;
	reg  [31:0]  lit_d;

	assign disp_ready = (state_q == ST_IDLE);
	assign take       = disp_valid && disp_ready;

	// an 8-pixel dispatch only carries two subspans, 16 only four
	always @*
	begin
		lit_d = disp_lit_mask;
		if (disp_simd == `PSP_SIMD8)
			lit_d = {24'h00_0000, disp_lit_mask[7:0]};
		else if (disp_simd == `PSP_SIMD16)
			lit_d = {16'h0000, disp_lit_mask[15:0]};
	end

	psp_subspan_mask u_mask_lo
	(
		.lit_mask  (lit_d[15:0]),
		.exec_mask (exec_d[15:0])
	);

	psp_subspan_mask u_mask_hi
	(
		.lit_mask  (lit_d[31:16]),
		.exec_mask (exec_d[31:16])
	);

	// ****************************************************************
	// header assembly
	// ****************************************************************
	always @*
	begin
		dw0_d = 32'h0000_0000;
		dw0_d[`PSP_DW0_VP_MSB:`PSP_DW0_VP_LSB]   = disp_viewport;
		dw0_d[`PSP_DW0_RTA_MSB:`PSP_DW0_RTA_LSB] = disp_rt_index;
		dw0_d[`PSP_DW0_FACE_BIT]  = disp_back_facing;
		dw0_d[`PSP_DW0_SRCZ_BIT]  = cfg_q[`PSP_CFG_SRCZ_BIT];
		dw0_d[`PSP_DW0_COVM_BIT]  = cfg_q[`PSP_CFG_COVM_BIT];
		dw0_d[`PSP_DW0_SSPI_BIT]  = disp_sspi;
		dw0_d[`PSP_DW0_TOPO_MSB:`PSP_DW0_TOPO_LSB] = disp_topology;
		hdr_d = 256'h0;
		hdr_d[31:0] = dw0_d;
		hdr_d[63:32+`PSP_DW1_CC_LSB] = disp_cc_ptr;
		hdr_d[127:96+`PSP_DW3_SAMP_LSB] = disp_sampler_ptr;
		hdr_d[99:96] = disp_scratch_size;
		hdr_d[159:128+`PSP_DW4_BIND_LSB] = disp_bind_ptr;
		hdr_d[191:160+`PSP_DW5_SCR_LSB] = disp_scratch_ptr;
		hdr_d[169:160+`PSP_DW5_COLOR_LSB] = disp_color_code;
		hdr_d[167:160] = disp_thread_tag;
		hdr_d[192+TID_W-1:192] = tid_q;
		hdr_d[224+`PSP_DW7_SNAP_BIT] = disp_snapshot;
		hdr_d[247:224] = disp_prim_tid;
	end

	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			simd_q    <= `PSP_SIMD8;
			bary_en_q <= 6'h00;
			hdr_q     <= 256'h0;
			r1_q      <= 256'h0;
			r2_q      <= 256'h0;
			exec_mask <= 32'h0000_0000;
			tid_q     <= `PSP_TID_RESET;
		end
		else if (take)
		begin
			simd_q    <= disp_simd;
			bary_en_q <= cfg_q[`PSP_CFG_BARY_MSB:`PSP_CFG_BARY_LSB];
			hdr_q     <= hdr_d;
			// mask above, copy below; dwords 6, 1 and 0 stay zero
			r1_q      <= {lit_d[15:0], lit_d[15:0], 32'h0000_0000,
				disp_coords[127:0], 64'h0};
			r2_q      <= {lit_d[31:16], lit_d[31:16], 32'h0000_0000,
				disp_coords[255:128], 64'h0};
			exec_mask <= exec_d;
			tid_q     <= tid_q + {{(TID_W-1){1'b0}}, 1'b1};
		end
	end

	// ****************************************************************
	// sequencer
	// ****************************************************************
	// steps walk the uncompacted numbering; a skipped step costs one
	// idle cycle, traded for a much simpler next-step search
	reg  [4:0] step_q;
	reg  [5:0] cnt_q;
	wire [4:0] bstep;
	wire       adv;
	wire [5:0] len_d;
	reg        incl;
	reg  [255:0] sel_data;

	assign bstep      = step_q - `PSP_STEP_BARY;
	assign bary_mode  = bstep[4:2];
	assign bary_group = bstep[1];
	assign bary_coef  = bstep[0];
	assign adv        = !pay_valid || pay_ready;
	// the final step may itself load a register, so count it here
	assign len_d      = incl ? cnt_q + 6'h01 : cnt_q;

	always @*
	begin
		incl     = 1'b0;
		sel_data = bary_data;
		case (step_q)
			`PSP_STEP_HDR:
			begin
				incl     = 1'b1;
				sel_data = hdr_q;
			end
			`PSP_STEP_R1:
			begin
				incl     = 1'b1;
				sel_data = r1_q;
			end
			`PSP_STEP_R2:
			begin
				incl     = (simd_q == `PSP_SIMD32);
				sel_data = r2_q;
			end
			default:
				incl = bary_en_q[bary_mode] &&
					!(simd_q == `PSP_SIMD8 && bary_group);
		endcase
	end

	// ****************************************************************
	// payload output
	// ****************************************************************
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_q    <= ST_IDLE;
			step_q     <= 5'h00;
			cnt_q      <= 6'h00;
			pay_valid  <= 1'b0;
			pay_index  <= 6'h00;
			pay_data   <= 256'h0;
			pay_end    <= 1'b0;
			pay_count  <= 6'h00;
			last_len_q <= 6'h00;
		end
		else
		begin
			pay_end <= 1'b0;
			if (pay_valid && pay_ready)
				pay_valid <= 1'b0;
			case (state_q)
				ST_IDLE:
				begin
					if (take)
					begin
						state_q <= ST_SEND;
						step_q  <= `PSP_STEP_HDR;
						cnt_q   <= 6'h00;
					end
				end
				ST_SEND:
				begin
					if (adv)
					begin
						if (incl)
						begin
							// next free position, no holes left behind
							pay_valid <= 1'b1;
							pay_index <= cnt_q;
							pay_data  <= sel_data;
							cnt_q     <= cnt_q + 6'h01;
						end
						if (step_q == `PSP_STEP_LAST)
						begin
							state_q    <= ST_IDLE;
							pay_end    <= 1'b1;
							pay_count  <= len_d;
							last_len_q <= len_d;
						end
						else
							step_q <= step_q + 5'h01;
					end
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end
endmodule // psp_payload_builder

// ### common/psp_map.vh
// constants for the pixel shader payload builder
`ifndef PSP_MAP_VH
`define PSP_MAP_VH

// ****************************************************************
// register port offsets
// ****************************************************************
`define PSP_ADDR_W          8
`define PSP_OFF_CFG         8'h00
`define PSP_OFF_STATUS      8'h04
`define PSP_OFF_LAST        8'h08

// ****************************************************************
// config register fields
// ****************************************************************
`define PSP_CFG_BARY_MSB    5
`define PSP_CFG_BARY_LSB    0
`define PSP_CFG_SRCZ_BIT    8
`define PSP_CFG_COVM_BIT    9
`define PSP_CFG_RESET       32'h0000_0000
`define PSP_STAT_BUSY_BIT   31

// ****************************************************************
// dispatch sizes
// ****************************************************************
`define PSP_SIMD8           2'h0
`define PSP_SIMD16          2'h1
`define PSP_SIMD32          2'h2

// ****************************************************************
// payload register numbering before compaction
// ****************************************************************
`define PSP_STEP_HDR        5'h00
`define PSP_STEP_R1         5'h01
`define PSP_STEP_R2         5'h02
`define PSP_STEP_BARY       5'h03
`define PSP_STEP_LAST       5'h1a

// ****************************************************************
// header dword zero fields
// ****************************************************************
`define PSP_DW0_VP_MSB      30
`define PSP_DW0_VP_LSB      27
`define PSP_DW0_RTA_MSB     26
`define PSP_DW0_RTA_LSB     16
`define PSP_DW0_FACE_BIT    15
`define PSP_DW0_SRCZ_BIT    13
`define PSP_DW0_COVM_BIT    12
`define PSP_DW0_SSPI_BIT    6
`define PSP_DW0_TOPO_MSB    4
`define PSP_DW0_TOPO_LSB    0

// ****************************************************************
// other header field positions
// ****************************************************************
`define PSP_DW1_CC_LSB      6
`define PSP_DW3_SAMP_LSB    5
`define PSP_DW4_BIND_LSB    5
`define PSP_DW5_SCR_LSB     10
`define PSP_DW5_COLOR_LSB   8
`define PSP_DW7_SNAP_BIT    31
`define PSP_TID_RESET       24'h00_0000

`endif

// ### rtl/psp_subspan_mask.v
// widens lit pixels of four subspans into a dispatch mask
`timescale 1ns/1ps
module psp_subspan_mask
(
	lit_mask,
	exec_mask
);
	input  wire [15:0] lit_mask;
	output wire [15:0] exec_mask;

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : g_span
			// any lit pixel enables its whole quad so derivatives stay valid
			assign exec_mask[4*g+3:4*g] = {4{|lit_mask[4*g+3:4*g]}};
		end
	endgenerate
endmodule // psp_subspan_mask

// ### testbench/psp_payload_chk_sva.sv
// port checker for the payload builder
`timescale 1ns/1ps
module psp_payload_chk
#(parameter TID_W = 24)
(
	input logic         clk_sys,
	input logic         reset_n,
	input logic         reg_rd,
	input logic [31:0]  reg_rdata,
	input logic         disp_valid,
	input logic         disp_ready,
	input logic [31:0]  exec_mask,
	input logic         pay_valid,
	input logic         pay_ready,
	input logic [5:0]   pay_index,
	input logic [255:0] pay_data,
	input logic         pay_end
);
	// **********
	// properties
	// **********
	function automatic logic whole(input logic [31:0] m);
		whole = 1'h1;
		for (int s = 0; s < 8; s++)
			if (m[4*s+:4] != 4'h0 && m[4*s+:4] != 4'hf)
				whole = 1'h0;
	endfunction
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence s_take; disp_valid && disp_ready; endsequence
	sequence s_accept; pay_valid && pay_ready; endsequence
	a_first_header: assert property (s_take ##0 !pay_valid |->
		##2 pay_valid && pay_index == 6'h00)
		else $error("header late");
	a_hold_payload: assert property (pay_valid && !pay_ready |=>
		pay_valid && $stable(pay_index) && $stable(pay_data))
		else $error("payload dropped while stalled");
	a_index_step: assert property (s_accept ##1 (pay_valid && pay_index != 6'h00) |->
		pay_index == $past(pay_index) + 6'h01)
		else $error("index gap");
	a_busy_refuse: assert property (s_take |=> !disp_ready [*8])
		else $error("dispatch taken while sending");
	a_end_pulse: assert property (pay_end |-> disp_ready ##1 !pay_end)
		else $error("end pulse wrong");
	a_dw2_zero: assert property (pay_valid && pay_index == 6'h00 |->
		pay_data[95:64] == 32'h0000_0000)
		else $error("header dword two not zero");
	a_hdr_reserved: assert property (pay_valid && pay_index == 6'h00 |->
		pay_data[223:216] == 8'h00 && pay_data[254:248] == 7'h00)
		else $error("reserved header bits set");
	a_mask_copy: assert property (pay_valid && pay_index == 6'h01 |->
		pay_data[255:240] == pay_data[239:224])
		else $error("mask copy differs");
	a_exec_whole: assert property (whole(exec_mask))
		else $error("partial subspan in dispatch mask");
	a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
		else $error("read data outside read slot");
endmodule // psp_payload_chk

bind psp_payload_builder psp_payload_chk #(.TID_W(TID_W)) u_chk (.clk_sys, .reset_n,
	.reg_rd, .reg_rdata, .disp_valid, .disp_ready, .exec_mask, .pay_valid, .pay_ready,
	.pay_index, .pay_data, .pay_end);

// ### testbench/psp_thread_model.sv
// thread side: takes payload registers, answers barycentric reads
`timescale 1ns/1ps
module psp_thread_model
(
	input logic          clk_sys,
	input logic          reset_n,
	input logic          slow,
	input logic [2:0]    bary_mode,
	input logic          bary_group,
	input logic          bary_coef,
	output logic [255:0] bary_data,
	output logic         pay_ready
);
	// **********
	// behaviour
	// **********
	logic [1:0] cnt_q;
	// every dword names its phase so a misplaced phase shows up
	assign bary_data = {8{16'hba00, 11'h000, bary_mode, bary_group, bary_coef}};
	always_ff @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
			cnt_q <= 2'h0;
		else
			cnt_q <= cnt_q + 2'h1;
	// slow stalls three cycles in four; payload only read, upper mask never written back
	assign pay_ready = !slow || cnt_q == 2'h3;
endmodule // psp_thread_model

// ### testbench/psp_payload_builder_bench.sv
// bench for the payload builder
`timescale 1ns/1ps
module psp_payload_builder_bench;
	logic clk_sys = 1'h0, reset_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, slow = 1'h0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, exec_mask, disp_lit_mask = 32'h0000_0000;
	logic disp_valid = 1'h0, disp_ready, disp_snapshot = 1'h1, disp_back_facing = 1'h0;
	logic disp_sspi = 1'h0, bary_group, bary_coef, pay_valid, pay_ready, pay_end;
	logic [1:0] disp_simd = 2'h0, disp_color_code = 2'h2;
	logic [23:0] disp_prim_tid = 24'h12_3456;
	logic [21:0] disp_scratch_ptr = 22'h2a_5a5a;
	logic [7:0] disp_thread_tag = 8'h5c;
	logic [26:0] disp_bind_ptr = 27'h2ab_cdef, disp_sampler_ptr = 27'h154_3210;
	logic [3:0] disp_scratch_size = 4'hb, disp_viewport = 4'hd;
	logic [25:0] disp_cc_ptr = 26'h1ab_cdef;
	logic [10:0] disp_rt_index = 11'h7ff;
	logic [4:0] disp_topology = 5'h13;
	logic [255:0] disp_coords, bary_data, pay_data;
	logic [2:0] bary_mode;
	logic [5:0] pay_index, pay_count, got_cnt;
	logic [255:0] got [0:15];
	int num_errors = 0, comparisons = 0, got_n;

	psp_payload_builder uut (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .disp_valid, .disp_ready, .disp_simd, .disp_snapshot, .disp_prim_tid,
		.disp_scratch_ptr, .disp_color_code, .disp_thread_tag, .disp_bind_ptr,
		.disp_sampler_ptr, .disp_scratch_size, .disp_cc_ptr, .disp_viewport, .disp_rt_index,
		.disp_back_facing, .disp_sspi, .disp_topology, .disp_lit_mask, .disp_coords,
		.bary_mode, .bary_group, .bary_coef, .bary_data, .exec_mask, .pay_valid, .pay_ready,
		.pay_index, .pay_data, .pay_end, .pay_count);
	psp_thread_model u_thr (.clk_sys, .reset_n, .slow, .bary_mode, .bary_group, .bary_coef,
		.bary_data, .pay_ready);

	// **********
	// helpers
	// **********
	initial forever #12.5 clk_sys = ~clk_sys;
	initial
	begin
		#1000000;
		num_errors++;
		close_out;
	end
	task close_out;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [255:0] g, input logic [255:0] e);
		comparisons++;
		if (g !== e)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a; reg_wdata <= d; reg_wr <= 1'h1;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a; reg_rd <= 1'h1;
		@(posedge clk_sys);
		reg_rd <= 1'h0;
		#1 d = reg_rdata;
	endtask
	function logic [255:0] hdr(input logic [23:0] tid, input logic [1:0] z);
		hdr = {disp_snapshot, 7'h00, disp_prim_tid, 8'h00, tid, disp_scratch_ptr,
			disp_color_code, disp_thread_tag, disp_bind_ptr, 5'h00, disp_sampler_ptr, 1'h0,
			disp_scratch_size, 32'h0000_0000, disp_cc_ptr, 6'h00, 1'h0, disp_viewport,
			disp_rt_index, disp_back_facing, 1'h0, z, 5'h00, disp_sspi, 1'h0, disp_topology};
	endfunction
	function logic [255:0] r1(input logic [15:0] m, input logic [127:0] c);
		r1 = {m, m, 32'h0000_0000, c, 64'h0000_0000_0000_0000};
	endfunction
	function logic [255:0] bx(input logic [2:0] m, input logic g, input logic c);
		bx = {8{16'hba00, 11'h000, m, g, c}};
	endfunction
	task run(input logic [1:0] simd, input logic [31:0] lit, input logic s);
		logic seen;
		seen = 1'h0;
		got_n = 0;
		@(posedge clk_sys);
		disp_simd <= simd; disp_lit_mask <= lit; slow <= s; disp_valid <= 1'h1;
		@(posedge clk_sys);
		disp_valid <= 1'h0;
		for (int i = 0; i < 400 && !(seen && !pay_valid); i++)
		begin
			@(posedge clk_sys);
			#1;
			if (pay_valid && pay_ready)
			begin
				got[pay_index[3:0]] = pay_data;
				got_n++;
			end
			if (pay_end)
			begin
				seen = 1'h1;
				got_cnt = pay_count;
			end
		end
		if (!seen)
		begin
			num_errors++;
			$display("unexpected at %0t: payload did not end", $time);
		end
	endtask

	// **********
	// scenarios
	// **********
	task t_regs;
		logic [31:0] d;
		rd(8'h04, d); chk(d, 32'h0000_0000);
		wr(8'h00, 32'h0000_0321);
		rd(8'h00, d); chk(d, 32'h0000_0321);
		wr(8'h04, 32'hffff_ffff);
		rd(8'h04, d); chk(d, 32'h0000_0000);
		rd(8'h0c, d); chk(d, 32'h0000_0000);
	endtask
	task t_simd16;
		wr(8'h00, 32'h0000_0321);
		run(2'h1, 32'h0000_0801, 1'h0);
		chk(got_cnt, 6'h0a); chk(got_n, 10);
		chk(exec_mask, 32'h0000_0f0f);
		chk(got[0], hdr(24'h00_0000, 2'h3));
		chk(got[1], r1(16'h0801, disp_coords[127:0]));
		for (int k = 0; k < 4; k++)
		begin
			chk(got[2+k], bx(3'h0, k[1], k[0]));
			chk(got[6+k], bx(3'h5, k[1], k[0]));
		end
	endtask
	task t_simd8;
		wr(8'h00, 32'h0000_001c);
		disp_back_facing <= 1'h1; disp_sspi <= 1'h1;
		run(2'h0, 32'h0000_ff31, 1'h0);
		chk(got_cnt, 6'h08); chk(got_n, 8);
		chk(exec_mask, 32'h0000_00ff);
		chk(got[0], hdr(24'h00_0001, 2'h0));
		chk(got[1][255:224], 32'h0031_0031);
		for (int j = 0; j < 3; j++)
		begin
			chk(got[2+2*j], bx(3'(2+j), 1'h0, 1'h0));
			chk(got[3+2*j], bx(3'(2+j), 1'h0, 1'h1));
		end
	endtask
	task t_simd32;
		logic [31:0] d;
		wr(8'h00, 32'h0000_0002);
		run(2'h2, 32'h2000_0000, 1'h1);
		chk(got_cnt, 6'h07); chk(got_n, 7);
		chk(exec_mask, 32'hf000_0000);
		chk(got[0], hdr(24'h00_0002, 2'h0));
		chk(got[1], r1(16'h0000, disp_coords[127:0]));
		chk(got[2], r1(16'h2000, disp_coords[255:128]));
		for (int k = 0; k < 4; k++)
			chk(got[3+k], bx(3'h1, k[1], k[0]));
		rd(8'h04, d); chk(d, 32'h0000_0003);
		rd(8'h08, d); chk(d, 32'h0000_0007);
	endtask

	initial
	begin
		for (int s = 0; s < 8; s++)
			disp_coords[32*s+:32] = {16'h0100 + 16'(s), 16'h0200 + 16'(s)};
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'h1;
		t_regs;
		t_simd16;
		t_simd8;
		t_simd32;
		close_out;
	end
endmodule // psp_payload_builder_bench
